// ===== tmcf_checker.sv
// Port-level assertions for the timer framework.
// Assumes it is bound onto tmcf_top and sees only its ports.
`timescale 1ns/1ps
`include "tmcf_map.vh"
module tmcf_checker (
    input wire clock,
    input wire arst_n,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire ct_pin,
    input wire ct_pin_oe,
    input wire ct_pin_inv,
    input wire ct_pin_inv_oe,
    input wire pt_pin,
    input wire pt_pin_oe,
    input wire pt_pin_inv,
    input wire pt_pin_inv_oe,
    input wire reference_pin_enable,
    input wire ct_int_a
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not idle");
    a_sel0_gap: assert property (rd && addr == `TMCF_PIN_SEL0 |=> !rdata[6])
        else $error("select 0 bit 6 set");
    a_sel1_upper: assert property (rd && addr == `TMCF_PIN_SEL1 |=> rdata[7:2] == 6'h00)
        else $error("select 1 upper bits set");
    a_ct_oe_follow: assert property (wr && addr == `TMCF_PIN_SEL0 |=> ##1 ct_pin_oe == $past(wdata[0], 2))
        else $error("compact enable wrong");
    a_ref_follow: assert property (wr && addr == `TMCF_PIN_SEL0 |=> ##1 reference_pin_enable == $past(wdata[7], 2))
        else $error("reference enable wrong");
    a_ct_gate: assert property (!ct_pin_oe |-> !ct_pin)
        else $error("compact pin driven while off");
    a_pt_gate: assert property (!pt_pin_inv_oe |-> !pt_pin_inv)
        else $error("periodic pin driven while off");
    a_ct_inv_pair: assert property (ct_pin_oe && ct_pin_inv_oe |-> ct_pin_inv != ct_pin)
        else $error("compact pins not complementary");
    a_pt_inv_pair: assert property (pt_pin_oe && pt_pin_inv_oe |-> pt_pin_inv != pt_pin)
        else $error("periodic pins not complementary");
    c_match: cover property (ct_int_a);
    c_high_read: cover property (rd && addr == `TMCF_CT_AH);
    c_pin_high: cover property (ct_pin_oe && ct_pin);
endmodule // tmcf_checker

// ===== tmcf_edge.v
// Two-flop synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin and the block clock.
`timescale 1ns/1ps
module tmcf_edge (
    input wire clock,
    input wire arst_n,
    input wire pin,
    output wire rise,
    output wire fall
);
    reg meta;
    reg sync;
    reg last;

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            last <= sync;
        end
    end

    // Edges seen only past the second flop
    assign rise = sync & ~last;
    assign fall = ~sync & last;
endmodule // tmcf_edge

// ===== tmcf_map.vh
// Register offsets, field positions, reset values and prescale counts
// for the timer framework. Byte-wide registers on a 5-bit address.
`ifndef TMCF_MAP_VH
`define TMCF_MAP_VH

`define TMCF_CT_C0 5'h00
`define TMCF_CT_C1 5'h01
`define TMCF_CT_DL 5'h02
`define TMCF_CT_DH 5'h03
`define TMCF_CT_AL 5'h04
`define TMCF_CT_AH 5'h05
`define TMCF_PT_C0 5'h08
`define TMCF_PT_C1 5'h09
`define TMCF_PT_DL 5'h0A
`define TMCF_PT_DH 5'h0B
`define TMCF_PT_AL 5'h0C
`define TMCF_PT_AH 5'h0D
`define TMCF_PT_RPL 5'h0E
`define TMCF_PT_RPH 5'h0F
`define TMCF_PIN_SEL0 5'h10
`define TMCF_PIN_SEL1 5'h11
`define TMCF_FLAGS 5'h12

// Control 0 fields
`define TMCF_C0_PAUSE 7
`define TMCF_C0_CK_HI 6
`define TMCF_C0_CK_LO 4
`define TMCF_C0_ON 3
// Control 1 fields
`define TMCF_C1_MODE_HI 7
`define TMCF_C1_MODE_LO 6
`define TMCF_C1_IO_HI 5
`define TMCF_C1_IO_LO 4
`define TMCF_C1_OC 3
`define TMCF_C1_POL 2
`define TMCF_C1_DPX 1
`define TMCF_C1_CAPSRC 1
`define TMCF_C1_CCLR 0

// Operating modes
`define TMCF_MODE_CMP 2'h0
`define TMCF_MODE_CAP 2'h1
`define TMCF_MODE_PWM 2'h2
`define TMCF_MODE_TMR 2'h3

// Pin-select bits
`define TMCF_PS0_REF 7
`define TMCF_PS0_PT1_INV 5
`define TMCF_PS0_PT1_TRUE 4
`define TMCF_PS0_PT0_INV 3
`define TMCF_PS0_PT0_TRUE 2
`define TMCF_PS0_CT0_INV 1
`define TMCF_PS0_CT0_TRUE 0
`define TMCF_PS1_CT1_INV 1
`define TMCF_PS1_CT1_TRUE 0

`define TMCF_RESET_BYTE 8'h00
`define TMCF_PS0_MASK 8'hBF
`define TMCF_PS1_MASK 8'h03

// Prescale counts for the clock select
`define TMCF_DIV_SYS4 2'h3
`define TMCF_DIV_H16 4'hF
`define TMCF_DIV_H64 6'h3F

`endif

// ===== tmcf_pins.sv
// Far-side pin model: external clock, trigger, capture and sub clock.
// Assumes pulse is called right after a rising clock edge.
`timescale 1ns/1ps
module tmcf_pins (
    input wire clock,
    output logic timer_clock_pin,
    output logic periodic_clock_pin,
    output logic capture_input_pin,
    output logic sub_clock_pin
);
    initial
    begin
        timer_clock_pin = 1'b0;
        periodic_clock_pin = 1'b0;
        capture_input_pin = 1'b0;
        sub_clock_pin = 1'b0;
    end
    // Three clocks per phase so the two-flop sync never drops an edge
    task pulse(input int n);
        repeat (n)
        begin
            timer_clock_pin <= 1'b1;
            repeat (3) @(posedge clock);
            timer_clock_pin <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    // Periodic side: dedicated capture pin or the periodic clock pin
    task cap_pulse(input int n, input logic on_clk);
        repeat (n)
        begin
            if (on_clk)
                periodic_clock_pin <= 1'b1;
            else
                capture_input_pin <= 1'b1;
            repeat (3) @(posedge clock);
            periodic_clock_pin <= 1'b0;
            capture_input_pin <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
endmodule // tmcf_pins

// ===== tmcf_tick.v
// Counter clock select: one-cycle count enable from the chosen source.
// Assumes edge pulses already synchronised to the block clock.
`timescale 1ns/1ps
`include "tmcf_map.vh"
module tmcf_tick (
    input wire clock,
    input wire arst_n,
    input wire [2:0] sel,
    input wire sub_rise,
    input wire pin_rise,
    input wire pin_fall,
    output reg tick
);
    reg [5:0] pre;

    // The high clock is taken as the block clock itself
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            pre <= 6'h00;
        else
            pre <= pre + 6'h01;
    end

    always @*
    begin
        case (sel)
            3'h0: tick = (pre[1:0] == `TMCF_DIV_SYS4);
            3'h1: tick = 1'b1;
            3'h2: tick = (pre[3:0] == `TMCF_DIV_H16);
            3'h3: tick = (pre == `TMCF_DIV_H64);
            3'h4: tick = sub_rise;
            3'h5: tick = sub_rise;
            3'h6: tick = pin_rise;
            default: tick = pin_fall;
        endcase
    end
endmodule // tmcf_tick

// ===== tmcf_top.v
// Timer framework: one compact and one periodic timer, the pin-select
// registers and the shared low-byte holding buffer.
// Assumes a byte-wide register port on the block clock; pins are async.
`timescale 1ns/1ps
`include "tmcf_map.vh"
module tmcf_top (
    input wire clock,
    input wire arst_n,
    input wire [4:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire timer_clock_pin,
    input wire periodic_clock_pin,
    input wire capture_input_pin,
    input wire sub_clock_pin,
    output reg ct_pin,
    output reg ct_pin_oe,
    output reg ct_pin_inv,
    output reg ct_pin_inv_oe,
    output reg pt_pin,
    output reg pt_pin_oe,
    output reg pt_pin_inv,
    output reg pt_pin_inv_oe,
    output reg reference_pin_enable,
    output reg periodic1_inverted_out_enable,
    output reg periodic1_true_out_enable,
    output reg compact1_inverted_out_enable,
    output reg compact1_true_out_enable,
    output reg ct_int_a,
    output reg ct_int_p,
    output reg pt_int_a,
    output reg pt_int_p
);
    parameter [7:0] PS0_MASK = `TMCF_PS0_MASK;
    parameter [7:0] PS1_MASK = `TMCF_PS1_MASK;

    reg [7:0] ct_c0;
    reg [7:0] ct_c1;
    reg [7:0] pt_c0;
    reg [7:0] pt_c1;
    reg [7:0] timer_pin_select_0;
    reg [7:0] timer_pin_select_1;
    reg [7:0] hold_buf;
    reg [9:0] ct_cnt;
    reg [9:0] pt_cnt;
    reg [9:0] ct_compare_a_value;
    reg [9:0] pt_compare_a_value;
    reg [9:0] pt_compare_p_value;
    reg ct_on_q;
    reg pt_on_q;
    reg ct_level;
    reg pt_level;
    reg pt_pulse;
    reg [3:0] flags;
    reg [7:0] rd_mux;

    wire ct_ck_rise;
    wire ct_ck_fall;
    wire pt_ck_rise;
    wire pt_ck_fall;
    wire cap_rise;
    wire cap_fall;
    wire sub_rise;
    wire ct_tick;
    wire pt_tick;

    tmcf_edge u_ct_ck (.clock(clock), .arst_n(arst_n), .pin(timer_clock_pin),
        .rise(ct_ck_rise), .fall(ct_ck_fall));
    tmcf_edge u_pt_ck (.clock(clock), .arst_n(arst_n), .pin(periodic_clock_pin),
        .rise(pt_ck_rise), .fall(pt_ck_fall));
    tmcf_edge u_cap (.clock(clock), .arst_n(arst_n), .pin(capture_input_pin),
        .rise(cap_rise), .fall(cap_fall));
    tmcf_edge u_sub (.clock(clock), .arst_n(arst_n), .pin(sub_clock_pin),
        .rise(sub_rise), .fall());

    tmcf_tick u_ct_tick (.clock(clock), .arst_n(arst_n),
        .sel(ct_c0[`TMCF_C0_CK_HI:`TMCF_C0_CK_LO]), .sub_rise(sub_rise),
        .pin_rise(ct_ck_rise), .pin_fall(ct_ck_fall), .tick(ct_tick));
    tmcf_tick u_pt_tick (.clock(clock), .arst_n(arst_n),
        .sel(pt_c0[`TMCF_C0_CK_HI:`TMCF_C0_CK_LO]), .sub_rise(sub_rise),
        .pin_rise(pt_ck_rise), .pin_fall(pt_ck_fall), .tick(pt_tick));

    // Next compare-mode level from the two-bit pin function
    function cmp_level;
        input [1:0] io;
        input cur;
        begin
            case (io)
                2'h0: cmp_level = cur;
                2'h1: cmp_level = 1'b0;
                2'h2: cmp_level = 1'b1;
                default: cmp_level = ~cur;
            endcase
        end
    endfunction

    // Period hit; zero period means the full 1024-count wrap
    function period_hit;
        input [9:0] period;
        input [9:0] cnt;
        begin
            if (period == 10'h000)
                period_hit = (cnt == 10'h3FF);
            else
                period_hit = (cnt + 10'h001) == period;
        end
    endfunction

    wire [1:0] ct_mode = ct_c1[`TMCF_C1_MODE_HI:`TMCF_C1_MODE_LO];
    wire [1:0] pt_mode = pt_c1[`TMCF_C1_MODE_HI:`TMCF_C1_MODE_LO];
    wire [1:0] ct_io = ct_c1[`TMCF_C1_IO_HI:`TMCF_C1_IO_LO];
    wire [1:0] pt_io = pt_c1[`TMCF_C1_IO_HI:`TMCF_C1_IO_LO];
    wire ct_on = ct_c0[`TMCF_C0_ON];
    wire pt_on = pt_c0[`TMCF_C0_ON];
    wire ct_step = ct_tick & ct_on & ~ct_c0[`TMCF_C0_PAUSE];
    wire pt_step = pt_tick & pt_on & ~pt_c0[`TMCF_C0_PAUSE];
    // Compact period is set by ct_c0[2:0] alone, in steps of 128 counts
    wire [9:0] ct_period = {ct_c0[2:0], 7'h00};
    wire [9:0] ct_inc = ct_cnt + 10'h001;
    wire [9:0] pt_inc = pt_cnt + 10'h001;

    wire ct_ma = ct_step & (ct_inc == ct_compare_a_value);
    wire ct_mp = ct_step & period_hit(ct_period, ct_cnt);
    wire pt_ma = pt_step & (pt_inc == pt_compare_a_value) & (pt_mode != `TMCF_MODE_CAP);
    wire pt_mp = pt_step & period_hit(pt_compare_p_value, pt_cnt);
    wire ct_ovf = ct_step & (ct_cnt == 10'h3FF);
    wire pt_ovf = pt_step & (pt_cnt == 10'h3FF);

    // PWM counter clears on the comparator chosen as period
    wire ct_clr_on_a = (ct_mode == `TMCF_MODE_PWM) ? ct_c1[`TMCF_C1_DPX] : ct_c1[`TMCF_C1_CCLR];
    wire pt_clr_on_a = (pt_mode == `TMCF_MODE_PWM) ? pt_c1[`TMCF_C1_DPX] : pt_c1[`TMCF_C1_CCLR];
    wire ct_clear = (ct_on & ~ct_on_q) | ct_ovf | (ct_clr_on_a ? ct_ma : ct_mp);
    wire pt_single = (pt_mode == `TMCF_MODE_PWM) && (pt_io == 2'h3);
    wire pt_trig = pt_single & pt_on & pt_ck_rise;
    wire pt_clear = (pt_on & ~pt_on_q) | pt_ovf | pt_trig |
        (pt_clr_on_a ? pt_ma : pt_mp);

    // Capture source: dedicated pin or the clock pin
    wire src_rise = pt_c1[`TMCF_C1_CAPSRC] ? pt_ck_rise : cap_rise;
    wire src_fall = pt_c1[`TMCF_C1_CAPSRC] ? pt_ck_fall : cap_fall;
    wire pt_cap = pt_on && (pt_mode == `TMCF_MODE_CAP) &&
        ((pt_io == 2'h0 && src_rise) || (pt_io == 2'h1 && src_fall) ||
        (pt_io == 2'h2 && (src_rise || src_fall)));

    // PWM duty: the comparator not used as period
    wire [9:0] ct_duty = ct_c1[`TMCF_C1_DPX] ? ct_period : ct_compare_a_value;
    wire [9:0] pt_duty = pt_c1[`TMCF_C1_DPX] ? pt_compare_p_value : pt_compare_a_value;
    wire ct_pwm_act = (ct_io == 2'h1) || (ct_io == 2'h2 && ct_cnt < ct_duty);
    wire pt_pwm_act = pt_single ? pt_pulse :
        ((pt_io == 2'h1) || (pt_io == 2'h2 && pt_cnt < pt_duty));

    wire ct_oc = ct_c1[`TMCF_C1_OC];
    wire pt_oc = pt_c1[`TMCF_C1_OC];
    wire ct_wave = ct_level ^ ct_c1[`TMCF_C1_POL];
    wire pt_wave = pt_level ^ pt_c1[`TMCF_C1_POL];
    wire flag_clr = wr && (addr == `TMCF_FLAGS);

    always @*
    begin
        rd_mux = 8'h00;
        case (addr)
            `TMCF_CT_C0: rd_mux = ct_c0;
            `TMCF_CT_C1: rd_mux = ct_c1;
            `TMCF_PT_C0: rd_mux = pt_c0;
            `TMCF_PT_C1: rd_mux = pt_c1;
            `TMCF_CT_DL: rd_mux = hold_buf;
            `TMCF_CT_AL: rd_mux = hold_buf;
            `TMCF_PT_DL: rd_mux = hold_buf;
            `TMCF_PT_AL: rd_mux = hold_buf;
            `TMCF_PT_RPL: rd_mux = hold_buf;
            `TMCF_CT_DH: rd_mux = {6'h00, ct_cnt[9:8]};
            `TMCF_CT_AH: rd_mux = {6'h00, ct_compare_a_value[9:8]};
            `TMCF_PT_DH: rd_mux = {6'h00, pt_cnt[9:8]};
            `TMCF_PT_AH: rd_mux = {6'h00, pt_compare_a_value[9:8]};
            `TMCF_PT_RPH: rd_mux = {6'h00, pt_compare_p_value[9:8]};
            `TMCF_PIN_SEL0: rd_mux = timer_pin_select_0;
            `TMCF_PIN_SEL1: rd_mux = timer_pin_select_1;
            `TMCF_FLAGS: rd_mux = {4'h0, flags};
            default: rd_mux = 8'h00;
        endcase
    end

    // Register port and shared holding buffer
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= 8'h00;
            hold_buf <= `TMCF_RESET_BYTE;
            ct_c0 <= `TMCF_RESET_BYTE;
            ct_c1 <= `TMCF_RESET_BYTE;
            pt_c0 <= `TMCF_RESET_BYTE;
            pt_c1 <= `TMCF_RESET_BYTE;
            timer_pin_select_0 <= `TMCF_RESET_BYTE;
            timer_pin_select_1 <= `TMCF_RESET_BYTE;
            ct_compare_a_value <= 10'h000;
            pt_compare_a_value <= 10'h000;
            pt_compare_p_value <= 10'h000;
        end
        else
        begin
            rdata <= rd ? rd_mux : 8'h00;
            if (rd)
            begin
                // High-byte read latches the low byte for the next read
                case (addr)
                    `TMCF_CT_DH: hold_buf <= ct_cnt[7:0];
                    `TMCF_CT_AH: hold_buf <= ct_compare_a_value[7:0];
                    `TMCF_PT_DH: hold_buf <= pt_cnt[7:0];
                    `TMCF_PT_AH: hold_buf <= pt_compare_a_value[7:0];
                    `TMCF_PT_RPH: hold_buf <= pt_compare_p_value[7:0];
                    default: hold_buf <= hold_buf;
                endcase
            end
            if (pt_cap)
                pt_compare_a_value <= pt_cnt;
            if (wr)
            begin
                case (addr)
                    `TMCF_CT_C0: ct_c0 <= wdata;
                    `TMCF_CT_C1: ct_c1 <= wdata;
                    `TMCF_PT_C0: pt_c0 <= wdata;
                    `TMCF_PT_C1: pt_c1 <= wdata;
                    `TMCF_CT_AL: hold_buf <= wdata;
                    `TMCF_PT_AL: hold_buf <= wdata;
                    `TMCF_PT_RPL: hold_buf <= wdata;
                    `TMCF_CT_AH: ct_compare_a_value <= {wdata[1:0], hold_buf};
                    `TMCF_PT_AH: pt_compare_a_value <= {wdata[1:0], hold_buf};
                    `TMCF_PT_RPH: pt_compare_p_value <= {wdata[1:0], hold_buf};
                    `TMCF_PIN_SEL0: timer_pin_select_0 <= wdata & PS0_MASK;
                    `TMCF_PIN_SEL1: timer_pin_select_1 <= wdata & PS1_MASK;
                    default: hold_buf <= hold_buf;
                endcase
            end
        end
    end

    // Counters, output levels and match flags
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ct_cnt <= 10'h000;
            pt_cnt <= 10'h000;
            ct_on_q <= 1'b0;
            pt_on_q <= 1'b0;
            ct_level <= 1'b0;
            pt_level <= 1'b0;
            pt_pulse <= 1'b0;
            flags <= 4'h0;
            ct_int_a <= 1'b0;
            ct_int_p <= 1'b0;
            pt_int_a <= 1'b0;
            pt_int_p <= 1'b0;
        end
        else
        begin
            ct_on_q <= ct_on;
            pt_on_q <= pt_on;
            if (ct_clear)
                ct_cnt <= 10'h000;
            else if (ct_step)
                ct_cnt <= ct_inc;
            if (pt_clear)
                pt_cnt <= 10'h000;
            else if (pt_step)
                pt_cnt <= pt_inc;

            // Compact: compare, PWM, or timer mode holding the pin
            if (ct_mode == `TMCF_MODE_CMP)
            begin
                if (ct_on & ~ct_on_q)
                    ct_level <= ct_oc;
                else if (ct_ma)
                    ct_level <= cmp_level(ct_io, ct_level);
            end
            else if (ct_mode == `TMCF_MODE_PWM)
                ct_level <= ct_pwm_act ? ct_oc : ~ct_oc;

            // Single pulse runs from trigger to comparator A match
            if (pt_trig)
                pt_pulse <= 1'b1;
            else if (pt_ma || !pt_on)
                pt_pulse <= 1'b0;
            if (pt_mode == `TMCF_MODE_CMP)
            begin
                if (pt_on & ~pt_on_q)
                    pt_level <= pt_oc;
                else if (pt_ma)
                    pt_level <= cmp_level(pt_io, pt_level);
            end
            else if (pt_mode == `TMCF_MODE_PWM)
                pt_level <= pt_pwm_act ? pt_oc : ~pt_oc;

            // Set wins over a same-cycle write-one clear
            flags[0] <= ct_ma | (flags[0] & ~(flag_clr & wdata[0]));
            flags[1] <= ct_mp | (flags[1] & ~(flag_clr & wdata[1]));
            flags[2] <= pt_ma | pt_cap | (flags[2] & ~(flag_clr & wdata[2]));
            flags[3] <= pt_mp | (flags[3] & ~(flag_clr & wdata[3]));
            ct_int_a <= ct_ma;
            ct_int_p <= ct_mp;
            pt_int_a <= pt_ma | pt_cap;
            pt_int_p <= pt_mp;
        end
    end

    // Pin drive; an unselected pin is released but the timer keeps running
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ct_pin <= 1'b0;
            ct_pin_oe <= 1'b0;
            ct_pin_inv <= 1'b0;
            ct_pin_inv_oe <= 1'b0;
            pt_pin <= 1'b0;
            pt_pin_oe <= 1'b0;
            pt_pin_inv <= 1'b0;
            pt_pin_inv_oe <= 1'b0;
            reference_pin_enable <= 1'b0;
            periodic1_inverted_out_enable <= 1'b0;
            periodic1_true_out_enable <= 1'b0;
            compact1_inverted_out_enable <= 1'b0;
            compact1_true_out_enable <= 1'b0;
        end
        else
        begin
            ct_pin_oe <= timer_pin_select_0[`TMCF_PS0_CT0_TRUE];
            ct_pin_inv_oe <= timer_pin_select_0[`TMCF_PS0_CT0_INV];
            pt_pin_oe <= timer_pin_select_0[`TMCF_PS0_PT0_TRUE];
            pt_pin_inv_oe <= timer_pin_select_0[`TMCF_PS0_PT0_INV];
            ct_pin <= timer_pin_select_0[`TMCF_PS0_CT0_TRUE] & ct_wave;
            ct_pin_inv <= timer_pin_select_0[`TMCF_PS0_CT0_INV] & ~ct_wave;
            pt_pin <= timer_pin_select_0[`TMCF_PS0_PT0_TRUE] & pt_wave;
            pt_pin_inv <= timer_pin_select_0[`TMCF_PS0_PT0_INV] & ~pt_wave;
            reference_pin_enable <= timer_pin_select_0[`TMCF_PS0_REF];
            periodic1_inverted_out_enable <= timer_pin_select_0[`TMCF_PS0_PT1_INV];
            periodic1_true_out_enable <= timer_pin_select_0[`TMCF_PS0_PT1_TRUE];
            compact1_inverted_out_enable <= timer_pin_select_1[`TMCF_PS1_CT1_INV];
            compact1_true_out_enable <= timer_pin_select_1[`TMCF_PS1_CT1_TRUE];
        end
    end
endmodule // tmcf_top

// ===== tmcf_top_tb_top.sv
// Self-checking bench for the timer framework.
// Assumes tmcf_top, tmcf_pins and tmcf_checker are compiled alongside.
`timescale 1ns/1ps
`include "tmcf_map.vh"
module tmcf_top_tb_top;
    logic clock, arst_n, wr, rd, rd_d, timer_clock_pin, periodic_clock_pin;
    logic capture_input_pin, sub_clock_pin, ct_pin, ct_pin_oe, ct_pin_inv, ct_pin_inv_oe;
    logic pt_pin, pt_pin_oe, pt_pin_inv, pt_pin_inv_oe, reference_pin_enable;
    logic periodic1_inverted_out_enable, periodic1_true_out_enable;
    logic compact1_inverted_out_enable, compact1_true_out_enable;
    logic ct_int_a, ct_int_p, pt_int_a, pt_int_p;
    logic [4:0] addr;
    logic [4:0] lo;
    logic [7:0] wdata, rdata, outs;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int err_count, num_checks, int_seen;
    int cap_seen, ct_p_seen, pt_p_seen;
    tmcf_top i_dut (.*);
    tmcf_pins i_pins (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want)
        begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task rd_reg(input logic [4:0] a, input logic [7:0] want);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        exp_q.push_back(want);
        @(posedge clock);
    endtask
    task idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    // Read data belongs to the read strobe one edge earlier
    always @(posedge clock)
    begin
        rd_d <= rd;
        if (ct_int_a === 1'b1)
            int_seen++;
        if (pt_int_a === 1'b1)
            cap_seen++;
        if (ct_int_p === 1'b1)
            ct_p_seen++;
        if (pt_int_p === 1'b1)
            pt_p_seen++;
        if (rd_d === 1'b1 && exp_q.size() > 0)
            check(rdata, exp_q.pop_front());
    end
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial
    begin
        #(50 * 40000);
        err_count++;
        close_out();
    end
    initial
    begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        seed = 32'h29942290;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd_reg(`TMCF_PIN_SEL0, 8'h00);
        rd_reg(`TMCF_PIN_SEL1, 8'h00);
        rd_reg(5'h1F, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            wr_reg(`TMCF_PIN_SEL0, seed[7:0] | 8'h40);
            rd_reg(`TMCF_PIN_SEL0, seed[7:0] & 8'hBF);
            wr_reg(`TMCF_PIN_SEL1, seed[15:8]);
            rd_reg(`TMCF_PIN_SEL1, seed[15:8] & 8'h03);
        end
        idle(2);
        outs = {reference_pin_enable, 1'b0, periodic1_inverted_out_enable,
            periodic1_true_out_enable, pt_pin_inv_oe, pt_pin_oe, ct_pin_inv_oe, ct_pin_oe};
        check(outs, seed[7:0] & 8'hBF);
        outs = {6'h00, compact1_inverted_out_enable, compact1_true_out_enable};
        check(outs, {6'h00, seed[9:8]});
        wr_reg(`TMCF_CT_C0, 8'h68);
        idle(1);
        i_pins.pulse(7);
        idle(4);
        rd_reg(`TMCF_CT_DH, 8'h00);
        rd_reg(`TMCF_CT_DL, 8'h07);
        wr_reg(`TMCF_CT_C0, 8'h70);
        wr_reg(`TMCF_CT_C0, 8'h78);
        idle(1);
        i_pins.pulse(5);
        idle(4);
        rd_reg(`TMCF_CT_DH, 8'h00);
        rd_reg(`TMCF_CT_DL, 8'h05);
        wr_reg(`TMCF_CT_C0, 8'h70);
        wr_reg(`TMCF_CT_AL, 8'h05);
        wr_reg(`TMCF_CT_AH, 8'h00);
        wr_reg(`TMCF_CT_C1, 8'h31);
        wr_reg(`TMCF_PIN_SEL0, 8'h0F);
        wr_reg(`TMCF_CT_C0, 8'h78);
        idle(1);
        i_pins.pulse(5);
        idle(4);
        check({7'h00, ct_pin}, 8'h01);
        check({7'h00, ct_pin_inv}, 8'h00);
        check(8'(int_seen), 8'h01);
        rd_reg(`TMCF_FLAGS, 8'h01);
        rd_reg(`TMCF_CT_DH, 8'h00);
        rd_reg(`TMCF_CT_DL, 8'h00);
        wr_reg(`TMCF_FLAGS, 8'h01);
        rd_reg(`TMCF_FLAGS, 8'h00);
        wr_reg(`TMCF_PIN_SEL0, 8'h00);
        idle(1);
        i_pins.pulse(5);
        idle(4);
        check({7'h00, ct_pin_oe}, 8'h00);
        check(8'(int_seen), 8'h02);
        wr_reg(`TMCF_CT_C0, 8'h00);
        // Alternate compare and period pairs through the one shared buffer
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            lo = i[0] ? `TMCF_PT_RPL : `TMCF_CT_AL;
            wr_reg(lo, seed[7:0]);
            wr_reg(lo + 5'h01, seed[15:8]);
            wr_reg(lo, ~seed[7:0]);
            rd_reg(lo + 5'h01, {6'h00, seed[9:8]});
            rd_reg(lo, seed[7:0]);
        end
        // Both period comparators on the fast clock: 64 and 128 counts
        wr_reg(`TMCF_CT_C1, 8'h00);
        wr_reg(`TMCF_PT_RPL, 8'h40);
        wr_reg(`TMCF_PT_RPH, 8'h00);
        wr_reg(`TMCF_PT_C0, 8'h18);
        wr_reg(`TMCF_CT_C0, 8'h19);
        idle(300);
        check(8'(pt_p_seen), 8'h04);
        check(8'(ct_p_seen), 8'h02);
        wr_reg(`TMCF_CT_C0, 8'h00);
        wr_reg(`TMCF_PT_C0, 8'h00);
        wr_reg(`TMCF_FLAGS, 8'h0F);
        // Capture on both edges, then on rising edges of the clock pin; idle sub clock keeps the counter at zero
        wr_reg(`TMCF_PT_AL, 8'h55);
        wr_reg(`TMCF_PT_AH, 8'h01);
        wr_reg(`TMCF_PT_C1, 8'h60);
        wr_reg(`TMCF_PT_C0, 8'h48);
        idle(1);
        i_pins.cap_pulse(2, 1'b0);
        idle(4);
        check(8'(cap_seen), 8'h04);
        wr_reg(`TMCF_PT_C1, 8'h42);
        idle(1);
        i_pins.cap_pulse(2, 1'b1);
        i_pins.cap_pulse(1, 1'b0);
        idle(4);
        check(8'(cap_seen), 8'h06);
        rd_reg(`TMCF_FLAGS, 8'h04);
        rd_reg(`TMCF_PT_AH, 8'h00);
        rd_reg(`TMCF_PT_AL, 8'h00);
        idle(3);
        close_out();
    end
endmodule // tmcf_top_tb_top
bind tmcf_top tmcf_checker i_chk (.*);
